// file: logic/tfa_cfg.svh
`ifndef TFA_CFG_SVH
`define TFA_CFG_SVH
// register byte offsets on the axi4-lite slave
`define TFA_REG_CTRL 8'h00
`define TFA_REG_STAT 8'h04
`define TFA_REG_OVRD 8'h08
// ctrl register fields
`define TFA_CTRL_USE_FIFO 0
`define TFA_CTRL_RATE_RST 1
`define TFA_CTRL_MARGIN 2
`define TFA_CTRL_FULL_RST 3
`define TFA_CTRL_CODING_RST 4
`define TFA_CTRL_ALIGN_GO 5
`define TFA_CTRL_MANUAL 6
`define TFA_CTRL_AUTO_RECOVER 7
`define TFA_CTRL_TX_PD 8
`define TFA_CTRL_NO_REFCLK 9
`define TFA_CTRL_SMOOTH 10
`define TFA_CTRL_PH_OVRD 11
`define TFA_CTRL_DLY_OVRD 12
`define TFA_CTRL_DLY_BYP 13
`define TFA_CTRL_RESET 32'h0000_0081
// stat register fields
`define TFA_STAT_HALF 0
`define TFA_STAT_ERR 1
`define TFA_STAT_ALIGNED 2
`define TFA_STAT_BUSY 3
`define TFA_STAT_RECOVERIES_LSB 8
// output clock selector codes
`define TFA_OCS_REFCLK 3'h3
`define TFA_OCS_OUTCLK 3'h5
`define TFA_OCS_PMA 3'h2
// reset pulse length, clock period and axi response codes
`define TFA_RST_NS 100
`define TFA_CLK_NS 4
`define TFA_RST_CYC ((`TFA_RST_NS + `TFA_CLK_NS - 1) / `TFA_CLK_NS)
`define TFA_RESP_OKAY 2'h0
`define TFA_RESP_SLVERR 2'h2
`endif

// file: logic/tfa_pkg.sv
package tfa_pkg;
  typedef struct packed {
    logic use_fifo;
    logic [2:0] clk_src;
    logic rate_auto_rst;
    logic margin_mode;
    logic reserved_byp;
    logic full_rst;
    logic coding_rst;
    logic pma_rst;
    logic [2:0] out_clk_sel;
  } tfa_cfg_t;
  typedef struct packed {
    logic hard_rst;
    logic soft_rst;
    logic ph_trig;
    logic ph_man_en;
    logic ph_init;
    logic pd;
    logic ph_ovrd;
    logic dly_ovrd;
    logic dly_byp;
    logic dly_man_en;
  } tfa_align_t;
  typedef struct packed {
    logic [1:0] fifo_status;
    logic soft_done;
    logic align_done;
    logic init_done;
  } tfa_dev_stat_t;
  typedef enum logic [3:0] {
    TFA_IDLE, TFA_RST, TFA_SOFT, TFA_INIT, TFA_PHASE, TFA_WAIT2, TFA_DELAY, TFA_DONE
  } tfa_state_t;
  typedef struct packed {
    tfa_state_t st;
    logic [31:0] ctrl;
    logic [7:0] cnt;
    logic [7:0] recov;
    logic done_prev;
    logic aligned;
    logic awr;
    logic wr;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tfa_state_all_t;
endpackage

// file: logic/tfa_ctrl.sv
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
`include "tfa_cfg.svh"
module tfa_ctrl (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire tfa_pkg::tfa_dev_stat_t dev_stat_in,
  output tfa_pkg::tfa_cfg_t dev_cfg_out,
  output tfa_pkg::tfa_align_t dev_align_out
);
  import tfa_pkg::*;

  tfa_state_all_t s_q, s_d;
  logic use_fifo, manual, fifo_err, done_rise, wr_go;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign use_fifo = s_q.ctrl[`TFA_CTRL_USE_FIFO];
  assign manual = s_q.ctrl[`TFA_CTRL_MANUAL];
  assign fifo_err = dev_stat_in.fifo_status[1];
  assign done_rise = dev_stat_in.align_done & ~s_q.done_prev;
  assign wr_go = s_q.awr & s_q.wr & ~s_q.bvalid;

  assign s_axi_awready_out = ~s_q.awr & ~s_q.bvalid;
  assign s_axi_wready_out = ~s_q.wr & ~s_q.bvalid;
  assign s_axi_arready_out = ~s_q.rvalid;
  assign s_axi_bvalid_out = s_q.bvalid;
  assign s_axi_bresp_out = s_q.bresp;
  assign s_axi_rvalid_out = s_q.rvalid;
  assign s_axi_rdata_out = s_q.rdata;
  assign s_axi_rresp_out = s_q.rresp;

  always_comb begin
    s_d = s_q;
    s_d.done_prev = dev_stat_in.align_done;
    // axi4-lite slave: address and data taken in either order
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      s_d.awr = 1'b1;
      s_d.awaddr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      s_d.wr = 1'b1;
      s_d.wdata = merge_bytes(s_q.ctrl, s_axi_wdata_in, s_axi_wstrb_in);
    end
    if (wr_go) begin
      s_d.awr = 1'b0;
      s_d.wr = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = `TFA_RESP_OKAY;
      if (s_q.awaddr == `TFA_REG_CTRL) begin
        s_d.ctrl = s_q.wdata;
      end else begin
        s_d.bresp = `TFA_RESP_SLVERR;
      end
    end
    if (s_q.bvalid && s_axi_bready_in) begin
      s_d.bvalid = 1'b0;
    end
    if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = `TFA_RESP_OKAY;
      s_d.rdata = 32'h0;
      case (s_axi_araddr_in)
        `TFA_REG_CTRL: s_d.rdata = s_q.ctrl;
        `TFA_REG_STAT: begin
          s_d.rdata[`TFA_STAT_HALF] = dev_stat_in.fifo_status[0];
          s_d.rdata[`TFA_STAT_ERR] = fifo_err;
          s_d.rdata[`TFA_STAT_ALIGNED] = s_q.aligned;
          s_d.rdata[`TFA_STAT_BUSY] = (s_q.st != TFA_IDLE) && (s_q.st != TFA_DONE);
          s_d.rdata[`TFA_STAT_RECOVERIES_LSB +: 8] = s_q.recov;
        end
        default: s_d.rresp = `TFA_RESP_SLVERR;
      endcase
    end else if (s_q.rvalid && s_axi_rready_in) begin
      s_d.rvalid = 1'b0;
    end
    // the one-shot align-go bit clears itself once taken
    s_d.ctrl[`TFA_CTRL_ALIGN_GO] = s_d.ctrl[`TFA_CTRL_ALIGN_GO] & (s_q.st != TFA_IDLE) ? 1'b0
                                   : s_d.ctrl[`TFA_CTRL_ALIGN_GO];
    if (s_q.cnt != 8'h0) begin
      s_d.cnt = s_q.cnt - 8'h1;
    end
    case (s_q.st)
      TFA_IDLE: begin
        if (use_fifo && fifo_err && s_q.ctrl[`TFA_CTRL_AUTO_RECOVER]) begin
          s_d.st = TFA_RST;
          // state is left on the cycle the count reads zero, so load one less
          s_d.cnt = 8'(`TFA_RST_CYC - 1);
          s_d.recov = s_q.recov + 8'h1;
        end else if (!use_fifo && s_q.ctrl[`TFA_CTRL_ALIGN_GO]) begin
          s_d.ctrl[`TFA_CTRL_ALIGN_GO] = 1'b0;
          s_d.aligned = 1'b0;
          s_d.st = s_q.ctrl[`TFA_CTRL_SMOOTH] ? TFA_RST : TFA_SOFT;
          s_d.cnt = 8'(`TFA_RST_CYC - 1);
        end
      end
      TFA_RST: begin
        if (s_q.cnt == 8'h0) begin
          s_d.st = use_fifo ? TFA_IDLE : TFA_SOFT;
        end
      end
      TFA_SOFT: begin
        if (dev_stat_in.soft_done) begin
          s_d.st = manual ? TFA_INIT : TFA_PHASE;
        end
      end
      TFA_INIT: begin
        if (dev_stat_in.init_done) begin
          s_d.st = TFA_PHASE;
        end
      end
      TFA_PHASE: begin
        if (done_rise) begin
          s_d.st = manual ? TFA_DELAY : TFA_WAIT2;
        end
      end
      TFA_WAIT2: begin
        if (done_rise) begin
          s_d.st = TFA_DONE;
        end
      end
      TFA_DELAY: begin
        if (done_rise) begin
          s_d.st = TFA_DONE;
        end
      end
      TFA_DONE: begin
        s_d.aligned = 1'b1;
        s_d.st = TFA_IDLE;
      end
      default: s_d.st = TFA_IDLE;
    endcase
    if (sys_rst_in) begin
      s_d = '0;
      s_d.ctrl = `TFA_CTRL_RESET;
      s_d.st = TFA_IDLE;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    s_q <= s_d;
  end

  always_comb begin
    dev_cfg_out.use_fifo = use_fifo;
    dev_cfg_out.clk_src = use_fifo ? `TFA_OCS_OUTCLK : `TFA_OCS_PMA;
    dev_cfg_out.rate_auto_rst = s_q.ctrl[`TFA_CTRL_RATE_RST];
    dev_cfg_out.margin_mode = s_q.ctrl[`TFA_CTRL_MARGIN];
    dev_cfg_out.reserved_byp = 1'b0;
    // recovery pulse reuses the coding-layer reset, alignment restart with the smooth bit set the pma reset
    dev_cfg_out.full_rst = s_q.ctrl[`TFA_CTRL_FULL_RST];
    dev_cfg_out.coding_rst = s_q.ctrl[`TFA_CTRL_CODING_RST] | (s_q.st == TFA_RST && use_fifo);
    dev_cfg_out.pma_rst = (s_q.st == TFA_RST) && !use_fifo;
    dev_cfg_out.out_clk_sel = use_fifo ? `TFA_OCS_OUTCLK : `TFA_OCS_REFCLK;
    dev_align_out.hard_rst = 1'b0;
    dev_align_out.soft_rst = (s_q.st == TFA_SOFT);
    dev_align_out.ph_trig = manual && (s_q.st == TFA_PHASE);
    dev_align_out.ph_man_en = manual && !use_fifo;
    dev_align_out.ph_init = manual && (s_q.st == TFA_INIT);
    dev_align_out.pd = use_fifo || s_q.ctrl[`TFA_CTRL_TX_PD] || s_q.ctrl[`TFA_CTRL_NO_REFCLK];
    dev_align_out.ph_ovrd = s_q.ctrl[`TFA_CTRL_PH_OVRD] && !use_fifo;
    dev_align_out.dly_ovrd = s_q.ctrl[`TFA_CTRL_DLY_OVRD] && !use_fifo;
    dev_align_out.dly_byp = s_q.ctrl[`TFA_CTRL_DLY_BYP];
    // a pending restart drops tracking at once, before the aligned flag clears
    dev_align_out.dly_man_en = manual && (s_q.st == TFA_DELAY ||
                               (s_q.aligned && !use_fifo && !s_q.ctrl[`TFA_CTRL_ALIGN_GO]));
  end

  sequence seq_soft_start;
    !use_fifo && s_q.st == TFA_IDLE && s_q.ctrl[`TFA_CTRL_ALIGN_GO] && !s_q.ctrl[`TFA_CTRL_SMOOTH];
  endsequence

  a_fifo_recover_pulse: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (s_q.st == TFA_IDLE && use_fifo && fifo_err && s_q.ctrl[`TFA_CTRL_AUTO_RECOVER]) |=> dev_cfg_out.coding_rst)
    else $error("fifo error did not raise the coding reset");
  a_auto_quiet: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !manual |-> !dev_align_out.ph_trig && !dev_align_out.ph_man_en && !dev_align_out.ph_init)
    else $error("manual alignment input active in auto mode");
  a_auto_dly_low: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !manual |-> !dev_align_out.dly_man_en)
    else $error("delay manual enable active in auto mode");
  a_pd_fifo: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    use_fifo |-> dev_align_out.pd)
    else $error("alignment circuit powered while fifo used");
  a_clk_pair: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (dev_cfg_out.clk_src == `TFA_OCS_OUTCLK) == dev_cfg_out.use_fifo)
    else $error("clock source does not match fifo use");
  a_refclk_sel: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !use_fifo |-> dev_cfg_out.out_clk_sel == `TFA_OCS_REFCLK)
    else $error("bypass without reference clock selector");
  a_soft_start: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    seq_soft_start |=> dev_align_out.soft_rst)
    else $error("soft reset not started");
  a_smooth_order: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    $fell(dev_cfg_out.pma_rst) && !use_fifo |-> dev_align_out.soft_rst)
    else $error("pma reset not followed by soft reset");
endmodule

// file: bench/tfa_dev_model.sv
`timescale 1ns/100ps
module tfa_dev_model
  import tfa_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire tfa_pkg::tfa_cfg_t cfg_in,
  input wire tfa_pkg::tfa_align_t aln_in,
  input wire logic half_in,
  input wire logic err_in,
  output tfa_pkg::tfa_dev_stat_t stat_out
);
  logic err_q, sr_q, dm_q, in_q, ad;
  logic [2:0] sc_q, mc_q;
  logic [5:0] t_q;
  always @(posedge clk_in) begin
    sr_q <= aln_in.soft_rst | aln_in.hard_rst;
    dm_q <= aln_in.dly_man_en;
    in_q <= aln_in.ph_init;
    if (rst_in || cfg_in.full_rst || cfg_in.coding_rst) err_q <= 1'b0;
    else if (err_in && cfg_in.use_fifo) err_q <= 1'b1;
    sc_q <= sr_q ? sc_q + {2'h0, sc_q != 3'h7} : 3'h0;
    if (rst_in || aln_in.pd) t_q <= 6'h0;
    else if (sr_q) t_q <= {5'h0, !aln_in.soft_rst && !aln_in.ph_man_en};
    else if (t_q != 6'h0 && t_q != 6'h3f) t_q <= t_q + 6'h1;
    // a fresh delay enable drops the done flag before it rises again
    if (rst_in || (aln_in.dly_man_en && !dm_q)) mc_q <= 3'h0;
    else if ((aln_in.ph_trig || aln_in.dly_man_en) && mc_q != 3'h7) mc_q <= mc_q + 3'h1;
  end
  // auto mode: short first pulse, then done stays up while delay tracking runs
  assign ad = (t_q >= 6'd5 && t_q < 6'd15) || t_q >= 6'd25 || mc_q == 3'h7;
  assign stat_out = {err_q, half_in & cfg_in.use_fifo, sc_q == 3'h7, ad, in_q};
endmodule

// file: bench/tfa_ctrl_tb_top.sv
`timescale 1ns/100ps
`include "tfa_cfg.svh"
module tfa_ctrl_tb_top;
  import tfa_pkg::*;
  logic clk, rst, awv, wv, bre, arv, rre, half, inj, man;
  logic [7:0] awa, ara;
  logic [31:0] wd, v;
  logic [3:0] ws;
  logic [65:0] re;
  wire awr, wrdy, arr, bv, rv;
  wire [1:0] br, rr;
  wire [31:0] rdat;
  tfa_dev_stat_t st;
  tfa_cfg_t cfg;
  tfa_align_t al;
  int n_fail = 0, checked = 0, seed = 23658;
  logic [65:0] rq[$];
  logic [1:0] bq[$];
  wire [5:0] mon = {al.dly_man_en, cfg.coding_rst, cfg.pma_rst, al.soft_rst, al.ph_init, al.ph_trig};
  tfa_ctrl DUT (.ref_clk_in(clk), .sys_rst_in(rst), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wrdy), .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(bre),
    .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rdat),
    .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rre), .dev_stat_in(st),
    .dev_cfg_out(cfg), .dev_align_out(al));
  tfa_dev_model PEER (.clk_in(clk), .rst_in(rst), .cfg_in(cfg), .aln_in(al), .half_in(half),
    .err_in(inj), .stat_out(st));
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  task chk(input string n, input logic [33:0] e, input logic [33:0] s);
    checked++;
    if (e !== s) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  task close_out;
    if (n_fail == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ad, dd;
    @(posedge clk);
    bq.push_back(r);
    awa <= a; wd <= d; ws <= 4'hf; awv <= 1; wv <= 1; bre <= 1; ad = 0; dd = 0;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (awr === 1 && !ad) begin ad = 1; awv <= 0; end
      if (wrdy === 1 && !dd) begin dd = 1; wv <= 0; end
    end
    while (bv !== 1) @(posedge clk);
    bre <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] r);
    @(posedge clk);
    rq.push_back({r, m, e});
    ara <= a; arv <= 1; rre <= 1;
    @(posedge clk);
    while (arr !== 1) @(posedge clk);
    arv <= 0;
    @(posedge clk);
    while (rv !== 1) @(posedge clk);
    rre <= 0;
  endtask
  // waits for a monitored level to rise, then measures how long it stays up
  task hold(input int k, input int n);
    int c;
    c = 0;
    while (mon[k] !== 1) @(negedge clk);
    while (mon[k] === 1) begin c++; @(negedge clk); end
    if (n > 0) chk("pulse_len", n, c);
  endtask
  always @(posedge clk) begin
    if (rv === 1 && rre === 1) begin
      re = rq.pop_front();
      chk("rdata", re[31:0] & re[63:32], rdat & re[63:32]);
      chk("rresp", re[65:64], rr);
    end
    if (bv === 1 && bre === 1) chk("bresp", bq.pop_front(), br);
    if (!rst && !man) chk("auto_ctl", 0, {al.ph_trig, al.ph_man_en, al.ph_init, al.dly_man_en, al.hard_rst});
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    close_out;
  end
  initial begin
    awv = 0; wv = 0; bre = 0; arv = 0; rre = 0; awa = 0; ara = 0; wd = 0; ws = 0;
    half = 0; inj = 0; man = 0; rst = 1;
    repeat (6) @(posedge clk);
    rst <= 0;
    rd(`TFA_REG_CTRL, `TFA_CTRL_RESET, 32'hffffffff, `TFA_RESP_OKAY);
    @(negedge clk);
    chk("fifo_cfg", {1'b1, 3'h5, 3'h5, 1'b0, 1'b1}, {cfg.use_fifo, cfg.clk_src, cfg.out_clk_sel, cfg.reserved_byp, al.pd});
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      half <= v[3];
      wr(`TFA_REG_CTRL, 32'h81 | (v & 32'h6), `TFA_RESP_OKAY);
      @(negedge clk);
      chk("rate_margin", v[2:1], {cfg.margin_mode, cfg.rate_auto_rst});
      rd(`TFA_REG_STAT, {31'h0, v[3]}, 32'h1, `TFA_RESP_OKAY);
    end
    inj <= 1;
    @(posedge clk);
    inj <= 0;
    hold(4, `TFA_RST_CYC);
    rd(`TFA_REG_STAT, 32'h100, 32'hff02, `TFA_RESP_OKAY);
    wr(`TFA_REG_CTRL, 32'h1, `TFA_RESP_OKAY);
    inj <= 1;
    @(posedge clk);
    inj <= 0;
    repeat (30) @(posedge clk);
    rd(`TFA_REG_STAT, 32'h2, 32'h2, `TFA_RESP_OKAY);
    wr(`TFA_REG_CTRL, 32'h9, `TFA_RESP_OKAY);
    wr(`TFA_REG_CTRL, 32'h1, `TFA_RESP_OKAY);
    rd(`TFA_REG_STAT, 32'h0, 32'h2, `TFA_RESP_OKAY);
    rd(8'h0c, 32'h0, 32'h0, `TFA_RESP_SLVERR);
    wr(`TFA_REG_STAT, 32'h0, `TFA_RESP_SLVERR);
    wr(`TFA_REG_CTRL, 32'h420, `TFA_RESP_OKAY);
    hold(3, `TFA_RST_CYC);
    hold(2, 0);
    chk("byp_cfg", {1'b0, 3'h2, 3'h3, 1'b0}, {cfg.use_fifo, cfg.clk_src, cfg.out_clk_sel, al.pd});
    repeat (40) @(negedge clk);
    rd(`TFA_REG_STAT, 32'h4, 32'h4, `TFA_RESP_OKAY);
    man <= 1;
    wr(`TFA_REG_CTRL, 32'h060, `TFA_RESP_OKAY);
    hold(2, 0);
    hold(1, 0);
    chk("man_en", 1, al.ph_man_en);
    hold(0, 0);
    while (mon[5] !== 1) @(negedge clk);
    repeat (20) @(negedge clk);
    chk("dly_track", 1, al.dly_man_en);
    rd(`TFA_REG_STAT, 32'h4, 32'h4, `TFA_RESP_OKAY);
    wr(`TFA_REG_CTRL, 32'h3940, `TFA_RESP_OKAY);
    @(negedge clk);
    chk("ovrd", 4'hf, {al.pd, al.ph_ovrd, al.dly_ovrd, al.dly_byp});
    close_out;
  end
endmodule
